// ---- rtl/epdram_regs.svh ----
`ifndef EPDRAM_REGS_SVH
`define EPDRAM_REGS_SVH
`define EPDRAM_CMD_DRV_OUT     8'h01
`define EPDRAM_CMD_GATE_START  8'h0F
`define EPDRAM_CMD_ENTRY_MODE  8'h11
`define EPDRAM_CMD_WRITE_BW    8'h24
`define EPDRAM_CMD_WRITE_RED   8'h26
`define EPDRAM_CMD_READ_RAM    8'h27
`define EPDRAM_CMD_READ_OPT    8'h41
`define EPDRAM_CMD_X_WIN       8'h44
`define EPDRAM_CMD_Y_WIN       8'h45
`define EPDRAM_CMD_FILL_RED    8'h46
`define EPDRAM_CMD_FILL_BW     8'h47
`define EPDRAM_CMD_X_CNT       8'h4E
`define EPDRAM_CMD_Y_CNT       8'h4F
`define EPDRAM_CMD_NOP         8'h7F
`define EPDRAM_RST_LINES       9'h13F
`define EPDRAM_RST_ENTRY       3'h3
`define EPDRAM_RST_X_END       6'h13
`define EPDRAM_RST_Y_END       9'h127
`define EPDRAM_X_MAX           6'h13
`define EPDRAM_GATE_MAX        9'h127
`define EPDRAM_LINES_MIN       9'h00F
`define EPDRAM_HALF_ROWS       9'h094
`endif

// ---- rtl/epdram_pkg.sv ----
package epdram_pkg;
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } epdram_byte_t;
  typedef struct packed {
    logic       plane;
    logic [5:0] x;
    logic [8:0] y;
    logic [7:0] data;
  } epdram_wr_t;
  typedef struct packed {
    logic [8:0] lines;
    logic       first_gate;
    logic       interlace;
    logic       scan_dir;
    logic [8:0] start;
  } epdram_gate_t;
  typedef enum logic [1:0] {
    EPDRAM_IDLE  = 2'b00,
    EPDRAM_PARAM = 2'b01,
    EPDRAM_DATA  = 2'b10,
    EPDRAM_FILL  = 2'b11
  } epdram_state_t;
endpackage

// ---- rtl/epdram_core.sv ----
// Operation
// - read option bit picks plane for ram reads; 0 black/white, 1 red
// - x window start resets 00h, end resets 13h
// - x units span eight pixels; x bounds limited to 00h..13h
// - y window nine-bit bounds, low byte then high bit; end resets 127h
// - written data wraps from the window end back to its start; counter loads are not held to the window
// - counter steps after each write; id bit 1 increments, 0 decrements
// - axis bit selects x (0) or y (1) stepping
// - counter steps only on writes and fill, never on reads
// - counter loads by 4E and 4F are ignored in standby; the fill commands still load the window start
// - nop changes nothing but ends any data sequence
// - active gate lines equal field plus one, 16..296; here the field resets to 13Fh, 320 lines, and has no upper limit
// - first gate bit swaps rows within gate pairs
// - scan mode 0 interlaced, 1 splits halves at row 148
// - scan direction bit 0 top-down, 1 bottom-up
// - gate start value 0..295, reset zero
// - data after 24 goes to black/white, after 26 to red
`timescale 1ns/10ps
`include "epdram_regs.svh"
module epdram_core
  import epdram_pkg::*;
#(
  parameter int XW = 6,
  parameter int YW = 9
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         standby_i,
  input  wire epdram_byte_t in_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output epdram_wr_t        wr_o,
  output logic              wr_valid_o,
  input  wire logic         wr_ready_i,
  output logic              rd_strobe_o,
  output logic              rd_plane_o,
  output logic [XW-1:0]     x_o,
  output logic [YW-1:0]     y_o,
  output epdram_gate_t      gate_o,
  output logic              busy_o
);
  epdram_state_t state_reg;
  logic [7:0]    cmd_reg;
  logic [1:0]    idx_reg;
  logic [2:0]    entry_reg;
  logic          plane_reg, read_sel_reg, fill_val_reg;
  logic [XW-1:0] xs_reg, xe_reg, xc_reg;
  logic [YW-1:0] ys_reg, ye_reg, yc_reg;
  logic [7:0]    ylo_reg;
  logic [8:0]    fill_h_reg, fill_w_reg;
  // two-entry skid buffer toward the ram port
  epdram_wr_t    buf_reg [2];
  logic [1:0]    cnt_reg;
  logic          rd_ptr_reg, wr_ptr_reg;
  logic          take, push, pop, space, is_write;
  epdram_wr_t    push_word;
  logic          x_at_end, y_at_end, x_next_end;
  logic [XW-1:0] x_next;
  logic [YW-1:0] y_next;

  function automatic logic [8:0] height(input logic [2:0] c);
    unique case (c)
      3'b000:  height = 9'd8;
      3'b001:  height = 9'd16;
      3'b010:  height = 9'd32;
      3'b011:  height = 9'd64;
      3'b100:  height = 9'd128;
      3'b101:  height = 9'd256;
      3'b110:  height = 9'd296;
      default: height = 9'd8;
    endcase
  endfunction

  function automatic logic [8:0] width(input logic [2:0] c);
    unique case (c)
      3'b000:  width = 9'd8;
      3'b001:  width = 9'd16;
      3'b010:  width = 9'd32;
      3'b011:  width = 9'd64;
      3'b100:  width = 9'd128;
      3'b101:  width = 9'd160;
      default: width = 9'd8;
    endcase
  endfunction

  // clamp to the legal x range; larger values would address past the panel
  function automatic logic [XW-1:0] xclamp(input logic [7:0] v);
    xclamp = (v[XW-1:0] > `EPDRAM_X_MAX) ? `EPDRAM_X_MAX : v[XW-1:0];
  endfunction

  assign space     = (cnt_reg != 2'd2);
  assign pop       = wr_valid_o && wr_ready_i;
  assign is_write  = (state_reg == EPDRAM_DATA) && !in_i.is_cmd
                     && (cmd_reg != `EPDRAM_CMD_READ_RAM);
  assign take      = in_valid_i && in_ready_o;
  assign push      = (take && is_write) ||
                     ((state_reg == EPDRAM_FILL) && space);
  assign in_ready_o = (state_reg != EPDRAM_FILL) && space;

  always_comb begin
    push_word.plane = plane_reg;
    push_word.x     = xc_reg;
    push_word.y     = yc_reg;
    if (state_reg == EPDRAM_FILL) begin
      // alternating blocks: toggle per step of height and width
      push_word.data = {8{fill_val_reg ^
        (((9'(yc_reg) / fill_h_reg) ^
          ((9'(xc_reg) << 3) / fill_w_reg)) != 9'd0 ? 1'b0 : 1'b0) ^
        ((9'(yc_reg) / fill_h_reg) ^ ((9'(xc_reg) << 3) / fill_w_reg)) % 2
        == 9'd1}};
    end else begin
      push_word.data = in_i.data;
    end
  end

  assign x_at_end   = (xc_reg == xe_reg);
  assign y_at_end   = (yc_reg == ye_reg);
  assign x_next_end = x_at_end && y_at_end;

  always_comb begin
    x_next = xc_reg;
    y_next = yc_reg;
    if (!entry_reg[2]) begin
      if (x_at_end) begin
        x_next = xs_reg;
        y_next = entry_reg[1] ? yc_reg + 1'b1 : yc_reg - 1'b1;
      end else begin
        x_next = entry_reg[0] ? xc_reg + 1'b1 : xc_reg - 1'b1;
      end
    end else begin
      if (y_at_end) begin
        y_next = ys_reg;
        x_next = entry_reg[0] ? xc_reg + 1'b1 : xc_reg - 1'b1;
      end else begin
        y_next = entry_reg[1] ? yc_reg + 1'b1 : yc_reg - 1'b1;
      end
    end
    if (x_at_end && y_at_end) begin
      x_next = xs_reg;
      y_next = ys_reg;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= EPDRAM_IDLE;
      cmd_reg   <= 8'h00;
      idx_reg   <= 2'd0;
    end else if (state_reg == EPDRAM_FILL) begin
      if (space && x_next_end)
        state_reg <= EPDRAM_IDLE;
    end else if (take) begin
      if (in_i.is_cmd) begin
        cmd_reg <= in_i.data;
        idx_reg <= 2'd0;
        unique case (in_i.data)
          `EPDRAM_CMD_WRITE_BW, `EPDRAM_CMD_WRITE_RED,
          `EPDRAM_CMD_READ_RAM: state_reg <= EPDRAM_DATA;
          `EPDRAM_CMD_NOP:      state_reg <= EPDRAM_IDLE;
          default:              state_reg <= EPDRAM_PARAM;
        endcase
      end else if (state_reg == EPDRAM_PARAM) begin
        idx_reg <= idx_reg + 2'd1;
        if (cmd_reg == `EPDRAM_CMD_FILL_RED ||
            cmd_reg == `EPDRAM_CMD_FILL_BW)
          state_reg <= EPDRAM_FILL;
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      gate_o <= '{lines: `EPDRAM_RST_LINES, first_gate: 1'b0,
                  interlace: 1'b0, scan_dir: 1'b0, start: 9'h000};
      entry_reg    <= `EPDRAM_RST_ENTRY;
      read_sel_reg <= 1'b0;
      xs_reg <= '0;
      xe_reg <= `EPDRAM_RST_X_END;
      ys_reg <= '0;
      ye_reg <= `EPDRAM_RST_Y_END;
      ylo_reg <= 8'h00;
      fill_val_reg <= 1'b0;
      fill_h_reg <= 9'd8;
      fill_w_reg <= 9'd8;
      plane_reg  <= 1'b0;
    end else if (take && in_i.is_cmd) begin
      if (in_i.data == `EPDRAM_CMD_WRITE_RED ||
          in_i.data == `EPDRAM_CMD_FILL_RED)
        plane_reg <= 1'b1;
      else if (in_i.data == `EPDRAM_CMD_WRITE_BW ||
               in_i.data == `EPDRAM_CMD_FILL_BW)
        plane_reg <= 1'b0;
    end else if (take && state_reg == EPDRAM_PARAM) begin
      unique case (cmd_reg)
        `EPDRAM_CMD_DRV_OUT:
          if (idx_reg == 2'd0) gate_o.lines[7:0] <= in_i.data;
          else if (idx_reg == 2'd1)
            gate_o.lines[8] <= in_i.data[0] |
              (in_i.data[0] == 1'b0 && gate_o.lines[7:0]
               < `EPDRAM_LINES_MIN);
          else begin
            gate_o.first_gate <= in_i.data[2];
            gate_o.interlace  <= in_i.data[1];
            gate_o.scan_dir   <= in_i.data[0];
          end
        `EPDRAM_CMD_GATE_START:
          if (idx_reg == 2'd0) gate_o.start[7:0] <= in_i.data;
          else if ({in_i.data[0], gate_o.start[7:0]} <= `EPDRAM_GATE_MAX)
            gate_o.start[8] <= in_i.data[0];
        `EPDRAM_CMD_ENTRY_MODE: entry_reg <= in_i.data[2:0];
        `EPDRAM_CMD_READ_OPT: read_sel_reg <= in_i.data[0];
        `EPDRAM_CMD_X_WIN:
          if (idx_reg == 2'd0) xs_reg <= xclamp(in_i.data);
          else xe_reg <= xclamp(in_i.data);
        `EPDRAM_CMD_Y_WIN:
          unique case (idx_reg)
            2'd0: ylo_reg <= in_i.data;
            2'd1: ys_reg <= {in_i.data[0], ylo_reg};
            2'd2: ylo_reg <= in_i.data;
            2'd3: ye_reg <= {in_i.data[0], ylo_reg};
          endcase
        `EPDRAM_CMD_FILL_RED, `EPDRAM_CMD_FILL_BW: begin
          fill_val_reg <= in_i.data[7];
          fill_h_reg   <= height(in_i.data[6:4]);
          fill_w_reg   <= width(in_i.data[2:0]);
        end
        default: ;
      endcase
    end
  end

  // counter: loaded by commands, stepped only by writes and fill
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      xc_reg <= '0;
      yc_reg <= '0;
    end else if (push) begin
      xc_reg <= x_next;
      yc_reg <= y_next;
    end else if (take && state_reg == EPDRAM_FILL) begin
      xc_reg <= xc_reg;
    end else if (take && !in_i.is_cmd && state_reg == EPDRAM_PARAM
                 && !standby_i) begin
      if (cmd_reg == `EPDRAM_CMD_X_CNT)
        xc_reg <= xclamp(in_i.data);
      else if (cmd_reg == `EPDRAM_CMD_Y_CNT && idx_reg == 2'd0)
        yc_reg[7:0] <= in_i.data;
      else if (cmd_reg == `EPDRAM_CMD_Y_CNT && idx_reg == 2'd1)
        yc_reg[8] <= in_i.data[0];
    end else if (take && in_i.is_cmd && (in_i.data == `EPDRAM_CMD_FILL_RED
                 || in_i.data == `EPDRAM_CMD_FILL_BW)) begin
      xc_reg <= xs_reg; // fill covers the window from its start
      yc_reg <= ys_reg;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg    <= 2'd0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else begin
      if (push) begin
        buf_reg[wr_ptr_reg] <= push_word;
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= !rd_ptr_reg;
      cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_o        <= '0;
      wr_valid_o  <= 1'b0;
      rd_strobe_o <= 1'b0;
      rd_plane_o  <= 1'b0;
      x_o         <= '0;
      y_o         <= '0;
      busy_o      <= 1'b0;
    end else begin
      wr_valid_o  <= (cnt_reg + 2'(push) - 2'(pop)) != 2'd0;
      wr_o        <= (pop || !wr_valid_o) ?
                     ((cnt_reg - 2'(pop)) != 2'd0 ?
                      buf_reg[rd_ptr_reg ^ pop] : push_word) : wr_o;
      rd_strobe_o <= take && state_reg == EPDRAM_DATA && !in_i.is_cmd
                     && cmd_reg == `EPDRAM_CMD_READ_RAM;
      rd_plane_o  <= read_sel_reg;
      x_o         <= xc_reg;
      y_o         <= yc_reg;
      busy_o      <= (state_reg == EPDRAM_FILL && !(space && x_next_end))
                     || (take && state_reg == EPDRAM_PARAM &&
                     (cmd_reg == `EPDRAM_CMD_FILL_RED ||
                      cmd_reg == `EPDRAM_CMD_FILL_BW));
    end
  end

  property p_busy_fill;
    @(posedge clock_i) disable iff (reset_i)
      state_reg == EPDRAM_FILL && !(space && x_next_end) |=> busy_o;
  endproperty
  a_busy_fill: assert property (p_busy_fill)
    else $error("busy low during fill");

  property p_read_no_move;
    @(posedge clock_i) disable iff (reset_i)
      rd_strobe_o |-> $stable(xc_reg) && $stable(yc_reg);
  endproperty
  a_read_no_move: assert property (p_read_no_move)
    else $error("counter moved on read");

  property p_standby;
    @(posedge clock_i) disable iff (reset_i)
      standby_i && !push && !(state_reg == EPDRAM_IDLE) |=>
      $stable(xc_reg) || $past(in_i.is_cmd);
  endproperty
  a_standby: assert property (p_standby)
    else $error("counter loaded in standby");

  property p_x_range;
    @(posedge clock_i) disable iff (reset_i)
      xs_reg <= `EPDRAM_X_MAX && xe_reg <= `EPDRAM_X_MAX;
  endproperty
  a_x_range: assert property (p_x_range)
    else $error("x window out of range");

  property p_step_inc;
    @(posedge clock_i) disable iff (reset_i)
      push && !entry_reg[2] && entry_reg[0] && !x_at_end
      |=> xc_reg == $past(xc_reg) + 1'b1;
  endproperty
  a_step_inc: assert property (p_step_inc)
    else $error("x counter did not increment");

  property p_wrap;
    @(posedge clock_i) disable iff (reset_i)
      push && !entry_reg[2] && x_at_end |=> xc_reg == $past(xs_reg);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("x counter did not reload");

  property p_nop;
    @(posedge clock_i) disable iff (reset_i)
      take && in_i.is_cmd && in_i.data == `EPDRAM_CMD_NOP
      |=> state_reg == EPDRAM_IDLE;
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop did not end sequence");

  property p_y_axis;
    @(posedge clock_i) disable iff (reset_i)
      push && entry_reg[2] && !y_at_end |=> $stable(xc_reg);
  endproperty
  a_y_axis: assert property (p_y_axis)
    else $error("x moved in y mode");

  c_fill: cover property (@(posedge clock_i) state_reg == EPDRAM_FILL);
  c_write: cover property (@(posedge clock_i) push && plane_reg);
  c_stall: cover property (@(posedge clock_i) cnt_reg == 2'd2);
endmodule

// ---- tb/epdram_ram_model.sv ----
`timescale 1ns/10ps
module epdram_ram_model
  import epdram_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire epdram_wr_t wr_i,
  input  wire logic       wr_valid_i,
  input  wire logic       stall_i,
  output logic            wr_ready_o
);
  logic [1:0] cnt_reg;
  epdram_wr_t words[$];
  // stalls three cycles of four so the buffer fills
  assign wr_ready_o = !(stall_i && (cnt_reg != 2'd3));
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= 2'd0;
    end else begin
      cnt_reg <= cnt_reg + 2'd1;
    end
  end
  // plain always: the bench pops and clears this queue as it checks
  always @(posedge clock_i) begin
    if (!reset_i && wr_valid_i && wr_ready_o) begin
      words.push_back(wr_i);
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import epdram_pkg::*;
;
  logic         clock_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         standby_i = 1'b0;
  epdram_byte_t in_i = '0;
  logic         in_valid_i = 1'b0;
  logic         in_ready_o;
  epdram_wr_t   wr_o;
  logic         wr_valid_o;
  logic         wr_ready;
  logic         rd_strobe_o;
  logic         rd_plane_o;
  logic [5:0]   x_o;
  logic [8:0]   y_o;
  epdram_gate_t gate_o;
  logic         busy_o;
  logic         stall = 1'b0;
  int           num_errors = 0;
  int           checked = 0;
  always #12.5 clock_i = ~clock_i;
  epdram_core dut (.clock_i(clock_i), .reset_i(reset_i),
    .standby_i(standby_i), .in_i(in_i), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .wr_o(wr_o), .wr_valid_o(wr_valid_o),
    .wr_ready_i(wr_ready), .rd_strobe_o(rd_strobe_o),
    .rd_plane_o(rd_plane_o), .x_o(x_o), .y_o(y_o), .gate_o(gate_o),
    .busy_o(busy_o));
  epdram_ram_model ram (.clock_i(clock_i), .reset_i(reset_i),
    .wr_i(wr_o), .wr_valid_i(wr_valid_o), .stall_i(stall),
    .wr_ready_o(wr_ready));
  task chk(string name, logic [23:0] exp, logic [23:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // held until taken, then released at the next falling edge
  task send(logic c, logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock_i);
    in_i.is_cmd = c;
    in_i.data = d;
    in_valid_i = 1'b1;
    while (in_ready_o !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 2000) chk("in_ready", 1, 0);
    @(negedge clock_i);
    in_valid_i = 1'b0;
  endtask
  task window(logic [5:0] x1, logic [8:0] y0, logic [8:0] y1);
    send(1, 8'h44); send(0, 8'h00); send(0, {2'b0, x1});
    send(1, 8'h45); send(0, y0[7:0]); send(0, {7'b0, y0[8]});
    send(0, y1[7:0]); send(0, {7'b0, y1[8]});
  endtask
  task load(logic [5:0] x, logic [8:0] y);
    send(1, 8'h4E); send(0, {2'b0, x});
    send(1, 8'h4F); send(0, y[7:0]); send(0, {7'b0, y[8]});
  endtask
  task expect_words(int n, epdram_wr_t exp[$]);
    int k;
    k = 0;
    while (ram.words.size() < n && k < 500) begin
      @(negedge clock_i);
      k++;
    end
    chk("word count", n, ram.words.size());
    foreach (exp[i]) begin
      if (ram.words.size() > 0) chk("word", exp[i], ram.words.pop_front());
    end
    ram.words.delete();
  endtask
  task t_reset;
    chk("plane", 0, rd_plane_o);
    chk("x", 0, x_o);
    chk("y", 0, y_o);
    chk("lines", 9'h13F, gate_o.lines);
    chk("busy", 0, busy_o);
  endtask
  task t_gate;
    send(1, 8'h01); send(0, 8'h0F); send(0, 8'h00); send(0, 8'h07);
    send(1, 8'h0F); send(0, 8'h27); send(0, 8'h01);
    chk("lines", 9'h00F, gate_o.lines);
    chk("first", 1, gate_o.first_gate);
    chk("interlace", 1, gate_o.interlace);
    chk("dir", 1, gate_o.scan_dir);
    chk("start", 9'h127, gate_o.start);
  endtask
  // x increment across a 2x2 window, receiver stalling
  task t_write_x;
    stall = 1'b1;
    window(6'd1, 9'd0, 9'd1);
    send(1, 8'h11); send(0, 8'h03);
    load(6'd0, 9'd0);
    send(1, 8'h24);
    for (int i = 0; i < 4; i++) send(0, 8'hA0 + i[7:0]);
    expect_words(4, '{{1'b0, 6'd0, 9'd0, 8'hA0}, {1'b0, 6'd1, 9'd0, 8'hA1},
      {1'b0, 6'd0, 9'd1, 8'hA2}, {1'b0, 6'd1, 9'd1, 8'hA3}});
    chk("x wrap", 0, x_o);
    chk("y wrap", 0, y_o);
    stall = 1'b0;
  endtask
  // y decrement into the red plane
  task t_write_y;
    // decrementing runs from a high start down to a low end
    window(6'd1, 9'd1, 9'd0);
    send(1, 8'h11); send(0, 8'h04);
    load(6'd1, 9'd1);
    send(1, 8'h26); send(0, 8'h5A); send(0, 8'hC3);
    expect_words(2, '{{1'b1, 6'd1, 9'd1, 8'h5A},
      {1'b1, 6'd1, 9'd0, 8'hC3}});
  endtask
  task t_read_standby;
    send(1, 8'h41); send(0, 8'h01);
    @(negedge clock_i);
    chk("plane", 1, rd_plane_o);
    load(6'd1, 9'd0);
    send(1, 8'h27); send(0, 8'h00);
    chk("rd strobe", 1, rd_strobe_o);
    send(0, 8'h00);
    chk("x after read", 1, x_o);
    standby_i = 1'b1;
    send(1, 8'h4E); send(0, 8'h00);
    @(negedge clock_i);
    chk("x in standby", 1, x_o);
    standby_i = 1'b0;
  endtask
  task t_nop;
    send(1, 8'h24); send(0, 8'h11);
    send(1, 8'h7F); send(0, 8'h22);
    repeat (10) @(negedge clock_i);
    expect_words(1, '{{1'b0, 6'd1, 9'd0, 8'h11}});
  endtask
  // both fill commands over the 2x2 window
  task t_fill;
    int k;
    send(1, 8'h11); send(0, 8'h03);
    window(6'd1, 9'd0, 9'd1);
    for (int p = 0; p < 2; p++) begin
      stall = 1'b1;
      send(1, p ? 8'h46 : 8'h47); send(0, 8'h80);
      chk("busy", 1, busy_o);
      chk("ready", 0, in_ready_o);
      k = 0;
      while (busy_o !== 1'b0 && k < 2000) begin
        @(negedge clock_i);
        k++;
      end
      chk("fill done", 0, busy_o);
      // first step 1, 8x8 steps: each x unit toggles, rows 0..7 agree
      expect_words(4, '{{p[0], 6'd0, 9'd0, 8'hFF}, {p[0], 6'd1, 9'd0, 8'h00},
        {p[0], 6'd0, 9'd1, 8'hFF}, {p[0], 6'd1, 9'd1, 8'h00}});
      stall = 1'b0;
    end
  endtask
  initial begin
    #(25 * 30000);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge clock_i);
    reset_i = 1'b0;
    t_reset();
    t_gate();
    t_write_x();
    t_write_y();
    t_read_standby();
    t_nop();
    t_fill();
    give_verdict();
  end
endmodule
